/* rtl/reset_interrupt_sequencer.v */
// Reset, interrupt and low-power sequencing with APB registers
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`include "rst_irq_defs.vh"
module reset_interrupt_sequencer
(
  // Clock and power-on reset
  input wire ref_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Pins and mask options
  input wire resetPin_n,
  input wire irqPin_n,
  input wire [3:0] portBPin,
  input wire oscIsCrystal,
  input wire extIrqLevelMode,
  // Timer events
  input wire captureEvent,
  input wire compareEvent,
  // CPU core handshakes
  input wire instrDone,
  input wire softTrapInstr,
  input wire returnFromTrapInstr,
  input wire stackedMask,
  input wire maskSetInstr,
  input wire maskClearInstr,
  input wire waitInstr,
  input wire stopInstr,
  // CPU core controls
  output wire cpuReset,
  output wire cpuHalt,
  output wire oscRun,
  output reg takeIrq,
  output reg [11:0] vectorAddr,
  output reg [11:0] stackPtr,
  output reg irqMask,
  // Peripheral configuration
  output reg [7:0] portADir,
  output reg [3:0] portBDir,
  output reg [7:0] portAOpenDrain,
  output reg compareOutputBit,
  output reg outputLevelSelect,
  output reg oscOutputEnable,
  output reg [15:0] timerCount
);
  // Sequencer states
  localparam ST_INIT = 3'd0;
  localparam ST_HOLD = 3'd1;
  localparam ST_DELAY = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_WAIT = 3'd4;
  localparam ST_STOP = 3'd5;
  localparam ST_WAKE = 3'd6;

  reg [2:0] state;
  reg [2:0] next_state;
  reg wakeLong;
  reg extLatch;
  reg irqPrev;
  reg [1:0] prescaler;
  reg [2:0] timerEn;
  reg [2:0] timerFlag;
  reg [2:0] timerArmed;
  reg extTimerClockEnable;
  reg noStartupDelay;
  reg [3:0] portBIrqEn;
  reg [3:0] portBFlag;
  reg delayLoad;
  reg [11:0] delayValue;
  reg takeNow;
  reg [31:0] readMux;
  wire delayDone;
  wire cfgClear;
  wire accessDone;
  wire wrEn;
  wire rdEn;
  wire extPending;
  wire timerPending;
  wire portBPending;
  wire anyPending;
  wire stopWake;
  wire timerTick;
  wire mapped;

  // Vector of the highest priority pending source
  function [11:0] pickVector;
    input ext;
    input tmr;
    begin
      if (ext)
        pickVector = `VEC_EXT; // see RL22
      else if (tmr)
        pickVector = `VEC_TIMER; // see RL24
      else
        pickVector = `VEC_PORTB; // see RL23
    end
  endfunction

  // Decode of a known register offset
  function isMapped;
    input [11:0] addr;
    begin
      isMapped = (addr <= `OFS_SEQ_STAT) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Bus handshake, zero wait states
  assign pready = 1'b1;
  assign accessDone = psel && penable;
  assign mapped = isMapped(paddr);
  assign pslverr = accessDone && !mapped;
  assign wrEn = accessDone && pwrite && mapped;
  assign rdEn = accessDone && !pwrite && mapped;
  assign prdata = readMux;

  // Reset state shown to the core and used to clear configuration
  assign cpuReset = (state == ST_INIT) || (state == ST_HOLD) || (state == ST_DELAY);
  assign cfgClear = cpuReset || !resetPin_n; // see RL10
  assign cpuHalt = (state == ST_WAIT) || (state == ST_STOP) || (state == ST_WAKE);
  assign oscRun = (state != ST_STOP); // see RL11

  // Pending requests; enables gate only the request
  assign extPending = extLatch || (extIrqLevelMode && !irqPin_n);
  assign timerPending = |(timerFlag & timerEn); // see RL5
  assign portBPending = |(portBFlag & portBIrqEn); // see RL5
  assign anyPending = extPending || timerPending || portBPending; // see RL4
  assign stopWake = extPending || portBPending
    || (timerPending && extTimerClockEnable); // see RL11

  // Timer ticks with oscillator, or with external clock in stop
  assign timerTick = oscRun || extTimerClockEnable;

  // Start-up delay counter
  startup_delay u_delay
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(delayLoad),
    .loadValue(delayValue),
    .done(delayDone)
  );

  // Next state, delay loads and interrupt acceptance
  always @*
  begin
    next_state = state;
    delayLoad = 1'b0;
    delayValue = `STARTUP_SHORT;
    takeNow = 1'b0;
    case (state)
      ST_INIT:
      begin
        delayLoad = 1'b1;
        delayValue = oscIsCrystal ? `STARTUP_LONG : `STARTUP_SHORT; // see RL2 RL3 RL20
        next_state = ST_DELAY;
      end
      ST_HOLD:
        if (resetPin_n)
        begin
          delayLoad = 1'b1;
          delayValue = wakeLong ? `STARTUP_LONG : `STARTUP_SHORT; // see RL19 RL20
          next_state = ST_DELAY;
        end
      ST_DELAY:
        if (delayDone)
          next_state = resetPin_n ? ST_RUN : ST_HOLD; // see RL2 RL3
      ST_RUN:
        if (softTrapInstr || (instrDone && !irqMask && anyPending))
          takeNow = 1'b1; // see RL8 RL21
        else if (waitInstr)
          next_state = ST_WAIT;
        else if (stopInstr)
          next_state = ST_STOP;
      ST_WAIT:
        if (anyPending)
        begin
          takeNow = 1'b1; // see RL12
          next_state = ST_RUN;
        end
      ST_STOP:
        if (stopWake)
        begin
          delayLoad = 1'b1;
          delayValue = noStartupDelay ? `STARTUP_SHORT : `STARTUP_LONG;
          next_state = ST_WAKE;
        end
      ST_WAKE:
        if (delayDone)
        begin
          takeNow = anyPending;
          next_state = ST_RUN;
        end
      default:
        next_state = ST_INIT;
    endcase
    // A low reset pin overrides every state
    if (!resetPin_n)
    begin
      next_state = ST_HOLD; // see RL1
      delayLoad = 1'b0;
      takeNow = 1'b0;
    end
  end

  // State register and stop latch for the restart delay
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_INIT;
      wakeLong <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (!resetPin_n && (state == ST_STOP || state == ST_WAKE))
        wakeLong <= 1'b1; // see RL19
      else if (state == ST_DELAY)
        wakeLong <= 1'b0;
    end
  end

  // Mask bit, vector, take pulse and stack pointer
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqMask <= 1'b1;
      takeIrq <= 1'b0;
      vectorAddr <= `VEC_RESET;
      stackPtr <= `SP_RESET;
    end
    else if (cfgClear)
    begin
      irqMask <= 1'b1; // see RL10
      takeIrq <= 1'b0;
      vectorAddr <= `VEC_RESET; // see RL10
      stackPtr <= `SP_RESET; // see RL18
    end
    else
    begin
      takeIrq <= takeNow;
      if (takeNow)
      begin
        irqMask <= 1'b1; // see RL8
        if (state == ST_RUN && softTrapInstr)
          vectorAddr <= `VEC_TRAP; // see RL21
        else
          vectorAddr <= pickVector(extPending, timerPending); // see RL25
      end
      else if (state == ST_RUN && (waitInstr || stopInstr))
        irqMask <= 1'b0; // see RL11 RL12
      else if (returnFromTrapInstr)
        irqMask <= stackedMask; // see RL9
      else if (maskSetInstr)
        irqMask <= 1'b1;
      else if (maskClearInstr)
        irqMask <= 1'b0;
    end
  end

  // Pin interrupt latch, falling edge sets, taking it clears
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      extLatch <= 1'b0;
      irqPrev <= 1'b1;
    end
    else
    begin
      irqPrev <= irqPin_n;
      if (cfgClear)
        extLatch <= 1'b0; // see RL19
      else if (irqPrev && !irqPin_n)
        extLatch <= 1'b1; // see RL22
      else if (takeNow && extPending && !(state == ST_RUN && softTrapInstr))
        extLatch <= 1'b0;
    end
  end

  // Free-running timer with divide-by-four prescaler
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prescaler <= 2'd0;
      timerCount <= `TIMER_RESET;
    end
    else if (cfgClear)
    begin
      prescaler <= 2'd0; // see RL13
      timerCount <= `TIMER_RESET; // see RL13
    end
    else if (timerTick)
    begin
      prescaler <= prescaler + 2'd1;
      if (prescaler == 2'd3)
        timerCount <= timerCount + 16'h0001;
    end
  end

  // Timer flags; status read arms, data access clears, set wins
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timerFlag <= 3'b000;
      timerArmed <= 3'b000;
    end
    else if (cfgClear)
    begin
      timerFlag <= 3'b000;
      timerArmed <= 3'b000;
    end
    else
    begin
      if (rdEn && paddr == `OFS_TIMER_STAT)
        timerArmed <= timerFlag; // see RL7
      else if (accessDone && paddr == `OFS_TIMER_DATA)
        timerArmed <= 3'b000;
      if (accessDone && paddr == `OFS_TIMER_DATA)
        timerFlag <= timerFlag & ~timerArmed; // see RL7
      if (captureEvent)
        timerFlag[2] <= 1'b1;
      if (compareEvent)
        timerFlag[1] <= 1'b1;
      if (timerTick && prescaler == 2'd3 && timerCount == 16'hffff)
        timerFlag[0] <= 1'b1;
    end
  end

  // Port B flags, one per line; a low pin sets, writing zero clears
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : gen_portb
      always @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          portBFlag[i] <= 1'b0;
        else if (cfgClear)
          portBFlag[i] <= 1'b0; // see RL17
        else if (!portBPin[i])
          portBFlag[i] <= 1'b1; // see RL17
        else if (wrEn && paddr == `OFS_PORTB_FLAG && !pwdata[i])
          portBFlag[i] <= 1'b0;
      end
    end
  endgenerate

  // Control registers written by software
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timerEn <= 3'b000;
      compareOutputBit <= 1'b0;
      outputLevelSelect <= 1'b0;
      extTimerClockEnable <= 1'b0;
      oscOutputEnable <= 1'b0;
      noStartupDelay <= 1'b0;
      portADir <= 8'h00;
      portBDir <= 4'h0;
      portAOpenDrain <= 8'h00;
      portBIrqEn <= 4'h0;
    end
    else if (cfgClear)
    begin
      timerEn <= 3'b000; // see RL14
      compareOutputBit <= 1'b0; // see RL14
      outputLevelSelect <= 1'b0; // see RL14
      extTimerClockEnable <= 1'b0; // see RL15
      oscOutputEnable <= 1'b0; // see RL15
      noStartupDelay <= 1'b0; // see RL15
      portADir <= 8'h00; // see RL16
      portBDir <= 4'h0; // see RL16
      portAOpenDrain <= 8'h00; // see RL16
      portBIrqEn <= 4'h0; // see RL17
    end
    else if (wrEn)
    begin
      case (paddr)
        `OFS_TIMER_CTRL:
        begin
          timerEn <= {pwdata[`TC_CAP_IEN], pwdata[`TC_CMP_IEN], pwdata[`TC_OVF_IEN]}; // see RL6
          compareOutputBit <= pwdata[`TC_CMP_OUT];
          outputLevelSelect <= pwdata[`TC_OUTPUT_LEVEL_SELECT];
        end
        `OFS_OSC_CTRL:
        begin
          extTimerClockEnable <= pwdata[`OC_EXT_CLK];
          oscOutputEnable <= pwdata[`OC_OSC_OUT];
          noStartupDelay <= pwdata[`OC_NO_DELAY];
        end
        `OFS_PORTA_DIR: portADir <= pwdata[7:0];
        `OFS_PORTB_DIR: portBDir <= pwdata[3:0];
        `OFS_PORTA_OD: portAOpenDrain <= pwdata[7:0];
        `OFS_PORTB_IEN: portBIrqEn <= pwdata[3:0];
        default: portBIrqEn <= portBIrqEn;
      endcase
    end
  end

  // Read data, zero for unmapped or write cycles
  always @*
  begin
    readMux = 32'h00000000;
    if (psel && !pwrite)
    begin
      case (paddr)
        `OFS_TIMER_CTRL:
        begin
          readMux[`TC_CAP_IEN] = timerEn[2];
          readMux[`TC_CMP_IEN] = timerEn[1];
          readMux[`TC_OVF_IEN] = timerEn[0];
          readMux[`TC_CMP_OUT] = compareOutputBit;
          readMux[`TC_OUTPUT_LEVEL_SELECT] = outputLevelSelect;
        end
        `OFS_TIMER_STAT:
        begin
          readMux[`TS_CAP] = timerFlag[2];
          readMux[`TS_CMP] = timerFlag[1];
          readMux[`TS_OVF] = timerFlag[0];
        end
        `OFS_TIMER_DATA: readMux[15:0] = timerCount;
        `OFS_OSC_CTRL:
        begin
          readMux[`OC_EXT_CLK] = extTimerClockEnable;
          readMux[`OC_OSC_OUT] = oscOutputEnable;
          readMux[`OC_NO_DELAY] = noStartupDelay;
        end
        `OFS_PORTA_DIR: readMux[7:0] = portADir;
        `OFS_PORTB_DIR: readMux[3:0] = portBDir;
        `OFS_PORTA_OD: readMux[7:0] = portAOpenDrain;
        `OFS_PORTB_IEN: readMux[3:0] = portBIrqEn;
        `OFS_PORTB_FLAG: readMux[3:0] = portBFlag; // see RL23
        `OFS_SEQ_STAT: readMux[5:0] = {extLatch, irqMask, wakeLong, state};
        default: readMux = 32'h00000000;
      endcase
    end
  end
endmodule

/* rtl/rst_irq_defs.vh */
// Constants for the reset and interrupt sequencer
// Summary of operation
// RL1: Reset pin must stay low at least one and a half bus cycles.
// RL2: Crystal option: power-on holds reset 4064 cycles, then while pin low.
// RL3: RC option: power-on delay only 2 cycles, then reset until pin high.
// RL4: Three maskable sources (pin, port B, timer) plus unmaskable soft trap.
// RL5: Cleared enable blocks the request but never stops the flag setting.
// RL6: Flags sit in read-only status registers, enables in separate registers.
// RL7: Flag clears by status read while set, then data register access.
// RL8: Interrupt taken at instruction end; stack, set mask, fetch vector.
// RL9: Return from trap restores saved state and resumes interrupted code.
// RL10: Reset forces reset vector and sets mask, leaving only soft trap.
// RL11: Stop halts oscillator until pin, port B, reset or ext-clock timer.
// RL12: Wait halts CPU, timer runs; reset or any interrupt ends it.
// RL13: Reset zeroes timer prescaler and loads counter just below wrap.
// RL14: Reset clears compare output, level select and timer enables.
// RL15: Reset clears external clock, oscillator output and no-delay bits.
// RL16: Reset clears port directions and port A open-drain register.
// RL17: Reset clears port B enables and flags; low pins set flags again.
// RL18: Reset loads stack pointer with top of stack area.
// RL19: Reset clears pin, wait and stop latches; stop exit uses full delay.
// RL20: Crystal power-on delay 4064 cycles; pin restart outside stop only 2.
// RL21: Soft trap ignores mask and vectors just below reset vector.
// RL22: Pin interrupt taken when mask clear and pin went low; own vector.
// RL23: Four port B lines share one vector; flags tell the source.
// RL24: Three timer flags share one timer vector.
// RL25: Several pending: service exactly one, leave others pending.
`ifndef RST_IRQ_DEFS_VH
`define RST_IRQ_DEFS_VH
// Start-up counts in bus cycles
`define STARTUP_LONG 12'd4064
`define STARTUP_SHORT 12'd2
// Vectors
`define VEC_RESET 12'hffe
`define VEC_TRAP 12'hffc
`define VEC_EXT 12'hffa
`define VEC_TIMER 12'hff8
`define VEC_PORTB 12'hff6
// Reset values
`define SP_RESET 12'h0ff
`define TIMER_RESET 16'hfffc
// Register byte offsets
`define OFS_TIMER_CTRL 12'h000
`define OFS_TIMER_STAT 12'h004
`define OFS_TIMER_DATA 12'h008
`define OFS_OSC_CTRL 12'h00c
`define OFS_PORTA_DIR 12'h010
`define OFS_PORTB_DIR 12'h014
`define OFS_PORTA_OD 12'h018
`define OFS_PORTB_IEN 12'h01c
`define OFS_PORTB_FLAG 12'h020
`define OFS_SEQ_STAT 12'h024
// Field positions
`define TC_CAP_IEN 7
`define TC_CMP_IEN 6
`define TC_OVF_IEN 5
`define TC_CMP_OUT 1
`define TC_OUTPUT_LEVEL_SELECT 0
`define TS_CAP 7
`define TS_CMP 6
`define TS_OVF 5
`define OC_EXT_CLK 0
`define OC_OSC_OUT 1
`define OC_NO_DELAY 2
`endif

/* rtl/startup_delay.v */
// Down counter timing oscillator start-up delays
`timescale 1ns/1ns
module startup_delay
(
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Load request and count
  input wire load,
  input wire [11:0] loadValue,
  // Delay elapsed
  output wire done
);
  reg [11:0] count;

  // Count down to zero after a load
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= 12'h000;
    else if (load)
      count <= loadValue;
    else if (count != 12'h000)
      count <= count - 12'h001;
  end

  assign done = (count == 12'h000) && !load;
endmodule

/* verification/cpu_core_model.sv */
// Behavioural CPU core: instruction boundaries, stacking and returns
`timescale 1ns/1ns
module cpu_core_model
(
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // From sequencer
  input wire takeIrq,
  input wire irqMask,
  input wire cpuReset,
  input wire cpuHalt,
  // To sequencer
  output logic instrDone,
  output logic returnFromTrapInstr,
  output wire stackedMask
);
  logic [1:0] phase;
  logic [4:0] svc;
  logic prevMask;
  logic saved;
  // Popped mask only valid with the return pulse, inverted otherwise
  assign stackedMask = returnFromTrapInstr ? saved : ~saved;
  // Boundary every fourth cycle; save mask on take, return after service
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      phase <= 2'h0;
      svc <= 5'h00;
      prevMask <= 1'b1;
      saved <= 1'b1;
      instrDone <= 1'b0;
      returnFromTrapInstr <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      prevMask <= irqMask;
      instrDone <= (phase == 2'h3) && !cpuReset && !cpuHalt;
      returnFromTrapInstr <= (svc == 5'h01);
      if (takeIrq)
      begin
        saved <= prevMask;
        svc <= 5'h14;
      end
      else if (svc != 5'h00)
        svc <= svc - 5'h01;
    end
endmodule

/* verification/reset_interrupt_sequencer_sva.sv */
// Checker for reset, interrupt and low-power sequencing
`timescale 1ns/1ns
module reset_interrupt_sequencer_sva
(
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Bus
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  // Core requests
  input wire softTrapInstr,
  input wire waitInstr,
  input wire stopInstr,
  // Core controls
  input wire cpuReset,
  input wire cpuHalt,
  input wire oscRun,
  input wire takeIrq,
  input wire [11:0] vectorAddr,
  input wire [11:0] stackPtr,
  input wire irqMask,
  // Configuration
  input wire [7:0] portADir,
  input wire [3:0] portBDir,
  input wire [7:0] portAOpenDrain,
  input wire compareOutputBit,
  input wire outputLevelSelect,
  input wire oscOutputEnable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire run = !cpuReset && !cpuHalt;
  rst_vec_a: assert property (cpuReset |-> vectorAddr == 12'hffe && irqMask)
    else $error("reset vector or mask wrong");
  rst_cfg_a: assert property (cpuReset && $past(cpuReset) |->
    {portADir, portBDir, portAOpenDrain, compareOutputBit, outputLevelSelect,
    oscOutputEnable} == 23'h0) else $error("config not cleared in reset");
  rst_sp_a: assert property (cpuReset |-> stackPtr == 12'h0ff)
    else $error("stack pointer wrong");
  take_mask_a: assert property (takeIrq |-> irqMask)
    else $error("mask clear on take");
  take_one_a: assert property (takeIrq |=> !takeIrq ##1 !takeIrq)
    else $error("take not single");
  take_vec_a: assert property (takeIrq |-> vectorAddr inside
    {12'hffc, 12'hffa, 12'hff8, 12'hff6}) else $error("bad vector");
  trap_vec_a: assert property (softTrapInstr && run |=> takeIrq && vectorAddr == 12'hffc)
    else $error("trap not taken");
  wait_entry_a: assert property (waitInstr && irqMask && !softTrapInstr && run
    |=> cpuHalt && oscRun && !irqMask) else $error("wait entry wrong");
  stop_entry_a: assert property (stopInstr && irqMask && !softTrapInstr && run
    |=> cpuHalt && !oscRun) else $error("stop entry wrong");
  bad_addr_a: assert property (psel && penable && paddr == 12'h028 |-> pslverr && prdata == 0)
    else $error("unmapped access accepted");
  trap_c: cover property (softTrapInstr && run);
  wait_c: cover property (cpuHalt && oscRun ##1 takeIrq);
  stop_c: cover property (!oscRun ##1 oscRun);
endmodule

/* verification/reset_interrupt_sequencer_tb.sv */
// Self-checking testbench for the reset and interrupt sequencer
`timescale 1ns/1ns
module reset_interrupt_sequencer_tb;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic resetPin_n = 1, irqPin_n = 1, oscIsCrystal = 1;
  logic [3:0] portB = 4'hf;
  logic [5:0] ev = 0;
  wire [31:0] prdata;
  wire [11:0] vectorAddr, stackPtr;
  wire [15:0] timerCount;
  wire pready, pslverr, cpuReset, cpuHalt, oscRun, takeIrq, irqMask, iDone, return_from_trap_instr, sMask;
  int failures = 0, compares = 0, n;
  // Bus cycle clock
  always #4 ref_clk = ~ref_clk;
  reset_interrupt_sequencer u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .resetPin_n(resetPin_n), .irqPin_n(irqPin_n),
    .portBPin(portB), .oscIsCrystal(oscIsCrystal), .extIrqLevelMode(1'b0),
    .captureEvent(ev[0]), .compareEvent(ev[0]), .instrDone(iDone), .softTrapInstr(ev[5]),
    .returnFromTrapInstr(return_from_trap_instr), .stackedMask(sMask), .maskSetInstr(ev[4]),
    .maskClearInstr(ev[3]), .waitInstr(ev[2]), .stopInstr(ev[1]), .cpuReset(cpuReset),
    .cpuHalt(cpuHalt), .oscRun(oscRun), .takeIrq(takeIrq), .vectorAddr(vectorAddr),
    .stackPtr(stackPtr), .irqMask(irqMask), .portADir(), .portBDir(), .portAOpenDrain(),
    .compareOutputBit(), .outputLevelSelect(), .oscOutputEnable(), .timerCount(timerCount));
  cpu_core_model u_core (.ref_clk(ref_clk), .reset_n(reset_n), .takeIrq(takeIrq),
    .irqMask(irqMask), .cpuReset(cpuReset), .cpuHalt(cpuHalt), .instrDone(iDone),
    .returnFromTrapInstr(return_from_trap_instr), .stackedMask(sMask));
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input [11:0] a, input [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      failures++;
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input [5:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 0;
  endtask
  task cnt;
    n = 0;
    @(posedge ref_clk);
    while (cpuReset !== 1'b0 && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task take(input [11:0] v, input int lim);
    int k;
    k = 0;
    while (takeIrq !== 1'b1 && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(takeIrq, 1);
    chk(vectorAddr, v);
    @(posedge ref_clk);
  endtask
  task svcB;
    portB <= 4'hf;
    apb(1, 12'h020, 0);
  endtask
  // Watchdog
  initial
  begin
    #240000;
    failures++;
    final_report;
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    chk(timerCount, 16'hfffc);
    chk(vectorAddr, 12'hffe);
    reset_n <= 1;
    cnt;
    chk(n >= 4064 && n <= 4070, 1);
    apb(1, 12'h000, 32'he3);
    apb(1, 12'h010, 32'hff);
    apb(1, 12'h01c, 32'hf);
    apb(1, 12'h018, 32'h5a);
    apb(0, 12'h000, 0);
    chk(rd, 32'he3);
    apb(0, 12'h028, 0);
    chk(rd, 0);
    // Pin reset with port B line 0 low
    resetPin_n <= 0;
    portB <= 4'he;
    repeat (2) @(posedge ref_clk);
    resetPin_n <= 1;
    cnt;
    chk(n <= 8, 1);
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h00c, 0);
    chk(rd, 0);
    apb(0, 12'h010, 0);
    chk(rd, 0);
    apb(0, 12'h018, 0);
    chk(rd, 0);
    apb(0, 12'h01c, 0);
    chk(rd, 0);
    apb(0, 12'h020, 0);
    chk(rd[0], 1);
    svcB;
    // External and port B pending together
    apb(1, 12'h01c, 32'h2);
    portB <= 4'hd;
    irqPin_n <= 0;
    pulse(6'h08);
    take(12'hffa, 20);
    irqPin_n <= 1;
    take(12'hff6, 40);
    svcB;
    // Timer flag with enables off, then two-step clear
    pulse(6'h01);
    apb(0, 12'h004, 0);
    chk(rd[7], 1);
    apb(0, 12'h008, 0);
    apb(0, 12'h004, 0);
    chk(rd[7], 0);
    pulse(6'h10);
    pulse(6'h20);
    take(12'hffc, 10);
    repeat (25) @(posedge ref_clk);
    // Enabled capture flag vectors through the timer entry
    apb(1, 12'h000, 32'h80);
    pulse(6'h01);
    pulse(6'h08);
    take(12'hff8, 20);
    apb(0, 12'h004, 0);
    apb(0, 12'h008, 0);
    apb(1, 12'h000, 0);
    pulse(6'h04);
    @(posedge ref_clk);
    chk(cpuHalt, 1);
    irqPin_n <= 0;
    take(12'hffa, 20);
    chk(cpuHalt, 0);
    irqPin_n <= 1;
    repeat (25) @(posedge ref_clk);
    apb(1, 12'h00c, 32'h4);
    pulse(6'h10);
    pulse(6'h02);
    @(posedge ref_clk);
    chk(oscRun, 0);
    portB <= 4'hd;
    take(12'hff6, 40);
    svcB;
    // Pin reset out of stop takes the full start-up delay
    pulse(6'h02);
    @(posedge ref_clk);
    resetPin_n <= 0;
    repeat (2) @(posedge ref_clk);
    resetPin_n <= 1;
    cnt;
    chk(n >= 4064 && n <= 4070, 1);
    // Second power-on with RC option
    reset_n <= 0;
    oscIsCrystal <= 0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1;
    cnt;
    chk(n >= 1 && n <= 6, 1);
    final_report;
  end
endmodule
bind reset_interrupt_sequencer reset_interrupt_sequencer_sva u_sva (.ref_clk(ref_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .softTrapInstr(softTrapInstr), .waitInstr(waitInstr),
  .stopInstr(stopInstr), .cpuReset(cpuReset), .cpuHalt(cpuHalt), .oscRun(oscRun),
  .takeIrq(takeIrq), .vectorAddr(vectorAddr), .stackPtr(stackPtr), .irqMask(irqMask),
  .portADir(portADir), .portBDir(portBDir), .portAOpenDrain(portAOpenDrain),
  .compareOutputBit(compareOutputBit), .outputLevelSelect(outputLevelSelect),
  .oscOutputEnable(oscOutputEnable));
